// file: src/timer8_pkg.sv
// Shared constants and carrier types for the 8-bit timer with two compare channels.
// Assumes a single 100 MHz clock and word-aligned register access over classic Wishbone.
package timer8_pkg;

   // Register indices; a register's byte address is four times its index
   localparam logic [7:0] IDX_CTRL_A = 8'h24;
   localparam logic [7:0] IDX_CTRL_B = 8'h25;
   localparam logic [7:0] IDX_COUNT = 8'h26;
   localparam logic [7:0] IDX_CMP_A = 8'h27;
   localparam logic [7:0] IDX_CMP_B = 8'h28;
   localparam logic [7:0] IDX_FLAGS = 8'h29;
   localparam logic [7:0] IDX_PIN_DIR = 8'h2a;

   // Field positions in timer_control_a
   localparam int CA_COM_A_LSB = 6;
   localparam int CA_COM_B_LSB = 4;
   localparam int CA_WGM_LSB = 0;
   // Field positions in timer_control_b
   localparam int CB_FORCE_A = 7;
   localparam int CB_FORCE_B = 6;
   localparam int CB_WGM_HIGH = 3;
   localparam int CB_CS_LSB = 0;
   // Flag positions in the flag register
   localparam int FL_MATCH_B = 2;
   localparam int FL_MATCH_A = 1;
   localparam int FL_OVF = 0;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] CMP_RST = 8'h00;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [1:0] DIR_RST = 2'h0;

   // Counter extremes
   localparam logic [7:0] MAX_VAL = 8'hff;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;

   // Prescaler taps: divide by 8, 64, 256 and 1024
   localparam int PRE_W = 10;
   localparam logic [PRE_W-1:0] PRE_MASK [4] = '{10'h007, 10'h03f, 10'h0ff, 10'h3ff};

   // Waveform modes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_CTC = 3'h2;
   localparam logic [2:0] WM_PHASE_A = 3'h5;
   localparam logic [2:0] WM_FAST_A = 3'h7;

   typedef enum logic [2:0] {
      CS_STOP = 3'b000,
      CS_DIV1 = 3'b001,
      CS_DIV8 = 3'b010,
      CS_DIV64 = 3'b011,
      CS_DIV256 = 3'b100,
      CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } clk_sel_t;

   typedef enum logic [1:0] {
      CLS_NONPWM = 2'b00,
      CLS_FAST = 2'b01,
      CLS_PHASE = 2'b10
   } wave_class_t;

   // Per-channel configuration
   typedef struct packed {
      wave_class_t cls;
      logic [1:0] com;
      logic toggle_ok;
   } wave_cfg_t;

   // Per-channel events, each valid for one cycle, plus the down and cmp_is_top levels
   typedef struct packed {
      logic match;
      logic force_hit;
      logic bottom;
      logic top;
      logic down;
      logic cmp_is_top;
   } wave_evt_t;

endpackage

// file: src/timer8_prescale.sv
// Free-running prescaler giving one-cycle enables at divisions of 8, 64, 256 and 1024.
// Assumes the enclosing timer picks one tap; the taps share one counter.
`timescale 1ns/10ps
`default_nettype none
module timer8_prescale (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Division enables
   output logic [3:0] div_en
);
   import timer8_pkg::*;

   logic [PRE_W-1:0] pre_r;

   // Shared counter, never stopped so all taps stay phase aligned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // One registered enable per tap
   for (genvar i = 0; i < 4; i++) begin : g_tap
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            div_en[i] <= 1'b0;
         end else begin
            div_en[i] <= (pre_r & PRE_MASK[i]) == PRE_MASK[i];
         end
      end
   end

endmodule
`default_nettype wire

// file: src/timer8_wave_unit.sv
// Waveform generator of one compare channel: holds the compare output level.
// Assumes the timer core feeds one-cycle match, force, bottom and top events.
`timescale 1ns/10ps
`default_nettype none
module timer8_wave_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Configuration and events
   input wire timer8_pkg::wave_cfg_t cfg,
   input wire timer8_pkg::wave_evt_t evt,
   // Output level
   output logic wave
);
   import timer8_pkg::*;

   logic wave_nxt;
   logic hit;

   // Next level from the channel mode
   always_comb begin
      wave_nxt = wave;
      // A match on TOP is dropped in PWM modes with the upper compare mode bit set
      hit = evt.match & ~(cfg.com[1] & evt.cmp_is_top & (cfg.cls != CLS_NONPWM));
      case (cfg.cls)
         CLS_NONPWM: begin
            if (evt.match | evt.force_hit) begin
               case (cfg.com)
                  2'b01: wave_nxt = ~wave;
                  2'b10: wave_nxt = 1'b0;
                  2'b11: wave_nxt = 1'b1;
                  default: wave_nxt = wave;
               endcase
            end
         end
         CLS_FAST: begin
            if (cfg.com[1]) begin
               if (hit) begin
                  wave_nxt = cfg.com[0];
               end else if (evt.bottom) begin
                  wave_nxt = ~cfg.com[0];
               end
            end else if (cfg.com[0] & cfg.toggle_ok & evt.match) begin
               wave_nxt = ~wave;
            end
         end
         CLS_PHASE: begin
            if (cfg.com[1]) begin
               if (hit) begin
                  wave_nxt = cfg.com[0] ^ evt.down;
               end else if (evt.top & evt.cmp_is_top) begin
                  wave_nxt = ~cfg.com[0];
               end
            end else if (cfg.com[0] & cfg.toggle_ok & evt.match) begin
               wave_nxt = ~wave;
            end
         end
         default: wave_nxt = wave;
      endcase
   end

   // Output register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wave <= 1'b0;
      end else begin
         wave <= wave_nxt;
      end
   end

endmodule
`default_nettype wire

// file: src/timer8_waveform_control.sv
// Top of the 8-bit timer: Wishbone registers, clock select, counter, compare and flags.
// Assumes a classic Wishbone master on SYS_CLK; the count pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module timer8_waveform_control (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [31:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Interrupt vector taken: bit 2 match B, bit 1 match A, bit 0 overflow
   input wire logic [2:0] VECTOR_DONE,
   // External count pin
   input wire logic EXT_COUNT_PIN,
   // Compare pins, enables active low
   output logic COMPARE_OUT_A,
   output logic COMPARE_OUT_A_OE_N,
   output logic COMPARE_OUT_B,
   output logic COMPARE_OUT_B_OE_N
);
   import timer8_pkg::*;

   logic ack_r;
   logic [31:0] dat_r;
   logic [1:0] out_a_compare_mode_r, out_b_compare_mode_r;
   logic [1:0] waveform_mode_low_r;
   logic waveform_mode_high_r;
   clk_sel_t clock_select_r;
   logic [7:0] counter_value_r;
   logic [7:0] compare_value_a_r, compare_value_b_r;
   logic [7:0] cmp_a_act_r, cmp_b_act_r;
   logic [2:0] flags_r;
   logic [1:0] pin_dir_r;
   logic [1:0] oe_n_r;
   logic down_r, block_r;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic [3:0] div_en;
   logic [1:0] wave;
   logic req, wr, mapped;
   logic [7:0] idx, wdat, rdata;
   logic [2:0] waveform_mode;
   wave_class_t cls;
   logic tick, at_top;
   logic [7:0] top_val, cnt_nxt;
   logic match_a, match_b, ovf_ev;
   logic force_a, force_b, upd_cmp, cnt_wr;
   logic [2:0] flag_set, flag_clr;
   wave_cfg_t cfg [2];
   wave_evt_t evt [2];

   // Bus decode; upper address bits must be zero to hit a register
   assign req = WB_CYC_I & WB_STB_I & ~ack_r;
   assign mapped = WB_ADR_I[31:10] == 22'h000000;
   assign idx = WB_ADR_I[9:2];
   assign wdat = WB_DAT_I[7:0];
   assign wr = req & WB_WE_I & WB_SEL_I[0] & mapped;
   assign cnt_wr = wr & (idx == IDX_COUNT);

   // Read mux; reserved and strobe bits read zero
   always_comb begin
      rdata = 8'h00;
      if (mapped) begin
         case (idx)
            IDX_CTRL_A: rdata = {out_a_compare_mode_r, out_b_compare_mode_r, 2'b00,
                                 waveform_mode_low_r};
            IDX_CTRL_B: rdata = {4'h0, waveform_mode_high_r, clock_select_r};
            IDX_COUNT: rdata = counter_value_r;
            IDX_CMP_A: rdata = compare_value_a_r;
            IDX_CMP_B: rdata = compare_value_b_r;
            IDX_FLAGS: rdata = {5'h00, flags_r};
            IDX_PIN_DIR: rdata = {6'h00, pin_dir_r};
            default: rdata = 8'h00;
         endcase
      end
   end

   // Answer one cycle after the request; unmapped reads return zero
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= req;
         if (req) begin
            dat_r <= {24'h000000, rdata};
         end
      end
   end
   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;

   // Control and compare buffer registers
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         out_a_compare_mode_r <= CTRL_RST[1:0];
         out_b_compare_mode_r <= CTRL_RST[1:0];
         waveform_mode_low_r <= CTRL_RST[1:0];
         waveform_mode_high_r <= 1'b0;
         clock_select_r <= CS_STOP;
         compare_value_a_r <= CMP_RST;
         compare_value_b_r <= CMP_RST;
         pin_dir_r <= DIR_RST;
      end else if (wr) begin
         case (idx)
            IDX_CTRL_A: begin
               out_a_compare_mode_r <= wdat[CA_COM_A_LSB +: 2];
               out_b_compare_mode_r <= wdat[CA_COM_B_LSB +: 2];
               waveform_mode_low_r <= wdat[CA_WGM_LSB +: 2];
            end
            IDX_CTRL_B: begin
               waveform_mode_high_r <= wdat[CB_WGM_HIGH];
               clock_select_r <= clk_sel_t'(wdat[CB_CS_LSB +: 3]);
            end
            IDX_CMP_A: compare_value_a_r <= wdat;
            IDX_CMP_B: compare_value_b_r <= wdat;
            IDX_PIN_DIR: pin_dir_r <= wdat[1:0];
            default: pin_dir_r <= pin_dir_r;
         endcase
      end
   end

   // Mode decode; reserved modes 4 and 6 behave as a plain non-PWM counter
   assign waveform_mode = {waveform_mode_high_r, waveform_mode_low_r};
   always_comb begin
      case (waveform_mode_low_r)
         2'b01: cls = CLS_PHASE;
         2'b11: cls = CLS_FAST;
         default: cls = CLS_NONPWM;
      endcase
   end
   // Compare A is TOP in modes 2, 5 and 7, else fixed MAX
   assign top_val = (waveform_mode == WM_CTC || waveform_mode == WM_PHASE_A ||
                     waveform_mode == WM_FAST_A) ? cmp_a_act_r : MAX_VAL;
   assign at_top = counter_value_r == top_val;

   // Strobes only act outside PWM; software keeps them zero in PWM modes
   assign force_a = wr & (idx == IDX_CTRL_B) & wdat[CB_FORCE_A] & (cls == CLS_NONPWM);
   assign force_b = wr & (idx == IDX_CTRL_B) & wdat[CB_FORCE_B] & (cls == CLS_NONPWM);

   // Count pin synchroniser; edges taken from the second and third stages
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= EXT_COUNT_PIN;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   timer8_prescale u_prescale (
      .clk(SYS_CLK),
      .rst(RST),
      .div_en(div_en)
   );

   // Timer tick select; pin direction is not consulted for the count pin
   always_comb begin
      case (clock_select_r)
         CS_STOP: tick = 1'b0;
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = div_en[0];
         CS_DIV64: tick = div_en[1];
         CS_DIV256: tick = div_en[2];
         CS_DIV1024: tick = div_en[3];
         CS_EXT_FALL: tick = ~ext_s2_r & ext_s3_r;
         CS_EXT_RISE: tick = ext_s2_r & ~ext_s3_r;
         default: tick = 1'b0;
      endcase
   end

   // Next count per mode
   always_comb begin
      if (cls == CLS_PHASE) begin
         if (!down_r) begin
            cnt_nxt = at_top ? counter_value_r - 8'h01 : counter_value_r + 8'h01;
         end else begin
            cnt_nxt = (counter_value_r == BOTTOM_VAL) ? counter_value_r + 8'h01 :
                      counter_value_r - 8'h01;
         end
      end else if (at_top) begin
         cnt_nxt = BOTTOM_VAL;
      end else begin
         cnt_nxt = counter_value_r + 8'h01;
      end
   end

   // Counter; a bus write wins over a tick
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         counter_value_r <= COUNT_RST;
      end else if (cnt_wr) begin
         counter_value_r <= wdat;
      end else if (tick) begin
         counter_value_r <= cnt_nxt;
      end
   end

   // Direction of the dual-slope count
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         down_r <= 1'b0;
      end else if (cls != CLS_PHASE) begin
         down_r <= 1'b0;
      end else if (tick) begin
         if (!down_r && at_top) begin
            down_r <= 1'b1;
         end else if (down_r && counter_value_r == BOTTOM_VAL) begin
            down_r <= 1'b0;
         end
      end
   end

   // Match block armed by a counter write, spent on the next tick
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         block_r <= 1'b0;
      end else if (cnt_wr) begin
         block_r <= 1'b1;
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   // Continuous comparators, sampled on the tick
   assign match_a = tick & ~block_r & (counter_value_r == cmp_a_act_r);
   assign match_b = tick & ~block_r & (counter_value_r == cmp_b_act_r);

   // Active compare values: immediate outside PWM, updated at TOP in both PWM classes
   always_comb begin
      case (cls)
         CLS_PHASE: upd_cmp = tick & at_top & ~down_r;
         CLS_FAST: upd_cmp = tick & at_top;
         default: upd_cmp = 1'b1;
      endcase
   end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cmp_a_act_r <= CMP_RST;
         cmp_b_act_r <= CMP_RST;
      end else if (upd_cmp) begin
         cmp_a_act_r <= compare_value_a_r;
         cmp_b_act_r <= compare_value_b_r;
      end
   end

   // Overflow: BOTTOM in phase modes, TOP in mode 7, MAX elsewhere
   always_comb begin
      if (cls == CLS_PHASE) begin
         ovf_ev = tick & down_r & (counter_value_r == BOTTOM_VAL);
      end else if (waveform_mode == WM_FAST_A) begin
         ovf_ev = tick & at_top;
      end else begin
         ovf_ev = tick & (counter_value_r == MAX_VAL);
      end
   end

   // Flags: set wins over a same-cycle clear; forced matches never set them
   assign flag_set = {match_b, match_a, ovf_ev};
   assign flag_clr = VECTOR_DONE | ({3{wr & (idx == IDX_FLAGS)}} & wdat[2:0]);
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         flags_r <= FLAGS_RST;
      end else begin
         flags_r <= flag_set | (flags_r & ~flag_clr);
      end
   end

   // Channel configuration and events; only channel A may toggle in PWM modes
   assign cfg[0] = '{cls: cls, com: out_a_compare_mode_r, toggle_ok: waveform_mode_high_r};
   assign cfg[1] = '{cls: cls, com: out_b_compare_mode_r, toggle_ok: 1'b0};
   assign evt[0] = '{match: match_a, force_hit: force_a, bottom: tick & at_top,
                     top: tick & at_top & ~down_r, down: down_r,
                     cmp_is_top: cmp_a_act_r == top_val};
   assign evt[1] = '{match: match_b, force_hit: force_b, bottom: tick & at_top,
                     top: tick & at_top & ~down_r, down: down_r,
                     cmp_is_top: cmp_b_act_r == top_val};

   // One waveform unit per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      timer8_wave_unit u_wave (
         .clk(SYS_CLK),
         .rst(RST),
         .cfg(cfg[ch]),
         .evt(evt[ch]),
         .wave(wave[ch])
      );
   end

   // Pin drive enables; disconnected channels release the pin
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         oe_n_r <= 2'b11;
      end else begin
         oe_n_r[0] <= ~((out_a_compare_mode_r != 2'b00) & pin_dir_r[0]);
         oe_n_r[1] <= ~((out_b_compare_mode_r != 2'b00) & pin_dir_r[1]);
      end
   end
   assign COMPARE_OUT_A = wave[0];
   assign COMPARE_OUT_B = wave[1];
   assign COMPARE_OUT_A_OE_N = oe_n_r[0];
   assign COMPARE_OUT_B_OE_N = oe_n_r[1];

   // Checks
   pin_route_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      ##1 COMPARE_OUT_B_OE_N == ~(($past(out_b_compare_mode_r) != 2'b00) & $past(pin_dir_r[1])))
      else $error("compare B pin enable wrong");
   reserved_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      req & ~WB_WE_I & mapped & (idx == IDX_CTRL_B) |=> WB_ACK_O && WB_DAT_O[7:4] == 4'h0)
      else $error("control B reserved or strobe bits nonzero");
   nonpwm_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (cls == CLS_NONPWM) && out_b_compare_mode_r == 2'b10 && match_b |=> !COMPARE_OUT_B)
      else $error("compare B not cleared on match");
   ctc_wrap_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      waveform_mode == WM_CTC && tick && at_top && !cnt_wr |=> counter_value_r == BOTTOM_VAL)
      else $error("clear-on-match counter did not return to zero");
   force_noflag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (force_a | force_b) && !tick && VECTOR_DONE == 3'h0 |=> flags_r == $past(flags_r))
      else $error("forced compare changed a flag");
   write_block_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      cnt_wr ##1 tick |-> !match_a && !match_b)
      else $error("match seen right after counter write");
   div8_rate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      clock_select_r == CS_DIV8 && tick |=> (!tick || clock_select_r != CS_DIV8)[*7])
      else $error("divide by 8 tick too soon");
   phase_turn_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      cls == CLS_PHASE && tick && at_top && !down_r && !cnt_wr |=> down_r)
      else $error("dual-slope count did not reverse at TOP");
   flag_wins_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      match_b |=> flags_r[FL_MATCH_B])
      else $error("match B flag lost");
   normal_wrap_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      waveform_mode == WM_NORMAL && tick && counter_value_r == MAX_VAL && !cnt_wr
      |=> counter_value_r == BOTTOM_VAL && flags_r[FL_OVF])
      else $error("normal mode wrap or overflow flag wrong");

endmodule
`default_nettype wire

// file: test/timer8_pin_model.sv
// Far side of the timer: drives the external count pin.
// Assumes the timer synchronises the pin to its own clock; the pin idles low.
`timescale 1ns/10ps
`default_nettype none
module timer8_pin_model (
   // Count pin
   output logic ext_pin
);
   initial ext_pin = 1'b0;
   // Each level held 50 ns so the three-stage synchroniser never misses it;
   // the 3 ns offset keeps every pin change away from a clock edge
   task automatic pulse(input int n);
      #3;
      repeat (n) begin
         #50 ext_pin = 1'b1;
         #50 ext_pin = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: test/timer8_waveform_control_tb.sv
// Self-checking bench for the 8-bit timer: registers, force strobes, count pin.
// Assumes a one-cycle Wishbone answer and a count pin seen 3 cycles late.
`timescale 1ns/10ps
`default_nettype none
module timer8_waveform_control_tb;
   import timer8_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [31:0] adr = '0, dat = '0, dat_o;
   logic [2:0] vec = 3'h0;
   logic ack, pin, oa, oa_n, ob, ob_n;
   logic [7:0] q[$];
   logic [7:0] v;
   int error_cnt = 0, num_checks = 0;
   always #5 clk = ~clk;
   timer8_pin_model pm (.ext_pin(pin));
   timer8_waveform_control uut (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
      .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .VECTOR_DONE(vec),
      .EXT_COUNT_PIN(pin), .COMPARE_OUT_A(oa), .COMPARE_OUT_A_OE_N(oa_n),
      .COMPARE_OUT_B(ob), .COMPARE_OUT_B_OE_N(ob_n));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {22'h0, idx, 2'h0};
      dat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      q.push_back(e);
      wb(1'b0, idx, 8'h00);
   endtask
   task automatic force_b(input logic [1:0] m);
      wb(1'b1, IDX_CTRL_A, {2'h0, m, 4'h0});
      wb(1'b1, IDX_CTRL_B, 8'h40);
      repeat (3) @(posedge clk);
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Read data is judged against the oldest note at each read ack
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
         chk(dat_o[7:0], q.pop_front());
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      void'($urandom(90));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(IDX_CTRL_B, CTRL_RST);
      rd(8'h30, 8'h00);
      wb(1'b1, IDX_CTRL_A, 8'hff);
      rd(IDX_CTRL_A, 8'hf3);
      wb(1'b1, IDX_CTRL_A, 8'h00);
      wb(1'b1, IDX_CTRL_B, 8'hc8);
      rd(IDX_CTRL_B, 8'h08);
      wb(1'b1, IDX_CTRL_B, 8'h00);
      v = 8'($urandom());
      wb(1'b1, IDX_COUNT, v);
      repeat (20) @(posedge clk);
      rd(IDX_COUNT, v);
      // Set, clear, then toggle output B by strobe
      wb(1'b1, IDX_PIN_DIR, 8'h02);
      for (int i = 0; i < 3; i++) begin
         force_b(2'(3 - i));
         chk({7'h0, ob}, {7'h0, i != 1});
         chk({7'h0, ob_n}, 8'h00);
      end
      rd(IDX_FLAGS, 8'h00);
      force_b(2'h2);
      wb(1'b1, IDX_CTRL_A, 8'h00);
      repeat (2) @(posedge clk);
      chk({7'h0, ob_n}, 8'h01);
      wb(1'b1, IDX_COUNT, 8'h00);
      wb(1'b1, IDX_CMP_B, 8'h05);
      wb(1'b1, IDX_CTRL_A, 8'h30);
      wb(1'b1, IDX_CTRL_B, 8'h07);
      pm.pulse(6);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h06);
      chk({7'h0, ob}, 8'h01);
      rd(IDX_FLAGS, 8'h04);
      wb(1'b1, IDX_FLAGS, 8'h04);
      rd(IDX_FLAGS, 8'h00);
      wb(1'b1, IDX_CTRL_B, 8'h06);
      pm.pulse(3);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h09);
      // Brief undivided run across the wrap point
      wb(1'b1, IDX_CTRL_B, 8'h00);
      wb(1'b1, IDX_COUNT, 8'hfe);
      wb(1'b1, IDX_CTRL_B, 8'h01);
      wb(1'b1, IDX_CTRL_B, 8'h00);
      rd(IDX_FLAGS, 8'h03);
      @(posedge clk);
      vec <= 3'h3;
      @(posedge clk);
      vec <= 3'h0;
      rd(IDX_FLAGS, 8'h00);
      // Clear-on-match: A toggles and wraps the count, B clears
      wb(1'b1, IDX_PIN_DIR, 8'h03);
      wb(1'b1, IDX_COUNT, 8'h00);
      wb(1'b1, IDX_CMP_A, 8'h03);
      wb(1'b1, IDX_CMP_B, 8'h02);
      wb(1'b1, IDX_CTRL_A, 8'h62);
      wb(1'b1, IDX_CTRL_B, 8'h07);
      pm.pulse(4);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h00);
      rd(IDX_FLAGS, 8'h06);
      chk({4'h0, oa, oa_n, ob, ob_n}, 8'h08);
      // Fast PWM with TOP from compare A, B non-inverting
      wb(1'b1, IDX_CTRL_B, 8'h08);
      wb(1'b1, IDX_CMP_B, 8'h01);
      wb(1'b1, IDX_COUNT, 8'h00);
      wb(1'b1, IDX_FLAGS, 8'h07);
      wb(1'b1, IDX_CTRL_A, 8'h23);
      wb(1'b1, IDX_CTRL_B, 8'h0f);
      pm.pulse(4);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h00);
      rd(IDX_FLAGS, 8'h07);
      chk({4'h0, oa, oa_n, ob, ob_n}, 8'h0e);
      pm.pulse(2);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h02);
      chk({7'h0, ob}, 8'h00);
      // Phase correct PWM with TOP from compare A
      wb(1'b1, IDX_CTRL_B, 8'h08);
      wb(1'b1, IDX_COUNT, 8'h00);
      wb(1'b1, IDX_FLAGS, 8'h07);
      wb(1'b1, IDX_CTRL_A, 8'h21);
      wb(1'b1, IDX_CTRL_B, 8'h0f);
      pm.pulse(7);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h01);
      rd(IDX_FLAGS, 8'h07);
      chk({7'h0, ob}, 8'h01);
      pm.pulse(1);
      repeat (5) @(posedge clk);
      rd(IDX_COUNT, 8'h02);
      chk({7'h0, ob}, 8'h00);
      // Divide by 8 for a while; its rate is watched by an assertion
      wb(1'b1, IDX_CTRL_B, 8'h02);
      repeat (40) @(posedge clk);
      wb(1'b1, IDX_CTRL_B, 8'h00);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule
`default_nettype wire
